/* opc_output_polarity_and_clock_status.sv */
// output polarity control, die identification and clock status registers
`timescale 1ns/100ps
`include "opc_params.svh"

module opc_output_polarity_and_clock_status #(
  parameter logic [7:0] DIE_ID = 8'h5A // arbitrary identification value
) (
  // clock and reset
  input  wire logic       mclk_i,
  input  wire logic       sys_rst_i,
  // register port from the control interface
  input  wire logic [7:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  output logic      [7:0] reg_rdata_o,
  output logic            reg_rvalid_o,
  // selected output sources and pin direction
  input  wire logic       aux_two_src_i,
  input  wire logic       mute_src_i,
  input  wire logic       aux_zero_src_i,
  input  wire logic       aux_io_two_dir_out_i,
  // pin drive
  output logic            aux_io_two_o,
  output logic            aux_io_two_oe_n_o,
  output logic            mute_o,
  output logic            aux_io_zero_o,
  // volume ramp state
  input  wire logic       left_volume_ramping_i,
  input  wire logic       left_volume_done_i,
  input  wire logic       right_volume_ramping_i,
  input  wire logic       right_volume_done_i,
  // clock detector results
  input  wire logic [2:0] detected_sample_rate_i,
  input  wire logic [3:0] detected_master_clock_ratio_i,
  input  wire logic       pll_enable_i,
  input  wire logic       mclk_over_limit_i,
  output logic            clock_error_o
);

  // register map, one byte at each offset:
  //   polarity control: bits 5, 4 and 3 invert aux two, mute and aux zero; other bits plain storage
  //   die identification: a constant, writes never land
  //   volume status: bits 5, 4, 1 and 0 follow the volume ramp live; bits 7, 6, 3 and 2 plain storage
  //   rate and ratio: bits 6-4 and 3-0 follow the clock detector live; bit 7 plain storage
  // unmapped offsets read zero with a valid answer, and writes to them are dropped
  // a read and a write in one cycle return the old contents, since reads come from the flops
  // register state
  logic [7:0] polarity;
  logic [7:0] vol_status;
  logic [7:0] rate_ratio;
  logic [7:0] next_polarity;
  logic [7:0] next_vol_status;
  logic [7:0] next_rate_ratio;
  logic [7:0] next_rdata;
  logic       next_rvalid;
  logic       next_oe_n;
  logic       next_clock_error;
  logic       next_aux_two;
  logic       pin_two;
  opc_pkg::opc_ratio_t ratio_code;
  opc_pkg::opc_rate_t  rate_code;

  // detector codes seen as their enum types for readable compares
  assign ratio_code = opc_pkg::opc_ratio_t'(detected_master_clock_ratio_i);
  assign rate_code  = opc_pkg::opc_rate_t'(detected_sample_rate_i);

  // next register contents: writable bits from the port, status bits live
  always_comb begin
    next_polarity   = polarity;
    next_vol_status = vol_status & `OPC_MASK_VOL_RW;
    next_rate_ratio = rate_ratio & `OPC_MASK_RATE_RW;
    if (reg_wr_i) begin
      unique case (reg_addr_i)
        `OPC_ADDR_POLARITY:   next_polarity   = reg_wdata_i;
        `OPC_ADDR_VOL_STATUS: next_vol_status = reg_wdata_i & `OPC_MASK_VOL_RW;
        `OPC_ADDR_RATE_RATIO: next_rate_ratio = reg_wdata_i & `OPC_MASK_RATE_RW;
        default:              next_polarity   = polarity;
      endcase
    end
    // live status bits override whatever a write placed there
    next_vol_status[`OPC_BIT_LEFT_RAMP]  = left_volume_ramping_i;
    next_vol_status[`OPC_BIT_LEFT_DONE]  = left_volume_done_i;
    next_vol_status[`OPC_BIT_RIGHT_RAMP] = right_volume_ramping_i;
    next_vol_status[`OPC_BIT_RIGHT_DONE] = right_volume_done_i;
    next_rate_ratio[`OPC_RATE_MSB:`OPC_RATE_LSB]   = detected_sample_rate_i;
    next_rate_ratio[`OPC_RATIO_MSB:`OPC_RATIO_LSB] = detected_master_clock_ratio_i;
  end

  // register storage
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      polarity   <= `OPC_RST_POLARITY;
      vol_status <= `OPC_RST_VOL_STATUS;
      rate_ratio <= `OPC_RST_RATE_RATIO;
    end else begin
      polarity   <= next_polarity;
      vol_status <= next_vol_status;
      rate_ratio <= next_rate_ratio;
    end
  end

  // the identification byte is a parameter, so a new die only changes the instance
  // read data; unmapped offsets read zero
  always_comb begin
    next_rvalid = reg_rd_i;
    next_rdata  = `OPC_RST_RDATA;
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        `OPC_ADDR_POLARITY:   next_rdata = polarity;
        `OPC_ADDR_DIE_ID:     next_rdata = DIE_ID;
        `OPC_ADDR_VOL_STATUS: next_rdata = vol_status;
        `OPC_ADDR_RATE_RATIO: next_rdata = rate_ratio;
        default:              next_rdata = `OPC_RST_RDATA;
      endcase
    end
  end

  // read answer registers: valid for one cycle, data back to zero after it
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      reg_rdata_o  <= `OPC_RST_RDATA;
      reg_rvalid_o <= 1'b0;
    end else begin
      reg_rdata_o  <= next_rdata;
      reg_rvalid_o <= next_rvalid;
    end
  end

  // the detector codes arrive on this clock, so no synchroniser is needed here;
  // a ratio code outside the list is flagged rather than trusted
  // clock error: bad codes, unusable ratio without pll, or clock too fast
  always_comb begin
    next_clock_error = 1'b0;
    // rate code out of range or unused
    if (rate_code == opc_pkg::OPC_FS_ERROR || rate_code == opc_pkg::OPC_FS_UNUSED) begin
      next_clock_error = 1'b1;
    end
    // ratio code marked as error or not in the list
    if (ratio_code == opc_pkg::OPC_RATIO_ERROR || ratio_code == opc_pkg::OPC_RATIO_RES5 ||
        ratio_code == opc_pkg::OPC_RATIO_RESC || ratio_code == opc_pkg::OPC_RATIO_RESF) begin
      next_clock_error = 1'b1;
    end
    // too few processing cycles per sample when the pll is off
    if (!pll_enable_i && detected_master_clock_ratio_i < `OPC_MIN_RATIO_NO_PLL) begin
      next_clock_error = 1'b1;
    end
    // master clock at or above its frequency limit
    if (mclk_over_limit_i) begin
      next_clock_error = 1'b1;
    end
  end

  // clock error register: one cycle behind the detector codes
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      clock_error_o <= 1'b0;
    end else begin
      clock_error_o <= next_clock_error;
    end
  end

  // aux output two drives only when set as an output; the extra level stage
  // keeps the pin level on a flop of this module, beside its enable
  always_comb begin
    next_oe_n    = ~aux_io_two_dir_out_i;
    next_aux_two = pin_two;
  end

  // pin direction and aux two level registers; the pin stays released in reset
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      aux_io_two_oe_n_o <= 1'b1;
      aux_io_two_o      <= 1'b0;
    end else begin
      aux_io_two_oe_n_o <= next_oe_n;
      aux_io_two_o      <= next_aux_two;
    end
  end

  // the three pins share one stage module; each resets low; mute and aux zero follow their source one cycle later, aux two two cycles later
  // aux output two polarity
  opc_polarity_stage u_aux_two (
    .mclk_i    (mclk_i),
    .sys_rst_i (sys_rst_i),
    .src_i     (aux_two_src_i),
    .invert_i  (polarity[`OPC_BIT_AUX_TWO_INV]),
    .pin_o     (pin_two)
  );

  // mute output polarity
  opc_polarity_stage u_mute (
    .mclk_i    (mclk_i),
    .sys_rst_i (sys_rst_i),
    .src_i     (mute_src_i),
    .invert_i  (polarity[`OPC_BIT_MUTE_INV]),
    .pin_o     (mute_o)
  );

  // aux output zero polarity
  opc_polarity_stage u_aux_zero (
    .mclk_i    (mclk_i),
    .sys_rst_i (sys_rst_i),
    .src_i     (aux_zero_src_i),
    .invert_i  (polarity[`OPC_BIT_AUX_ZERO_INV]),
    .pin_o     (aux_io_zero_o)
  );

endmodule : opc_output_polarity_and_clock_status

/* opc_params.svh */
// constants for the output polarity and clock status register group
`ifndef OPC_PARAMS_SVH
`define OPC_PARAMS_SVH

// register offsets
`define OPC_ADDR_POLARITY     8'h57
`define OPC_ADDR_DIE_ID       8'h58
`define OPC_ADDR_VOL_STATUS   8'h59
`define OPC_ADDR_RATE_RATIO   8'h5B

// reset values
`define OPC_RST_POLARITY      8'h00
`define OPC_RST_VOL_STATUS    8'h00
`define OPC_RST_RATE_RATIO    8'h00
`define OPC_RST_RDATA         8'h00

// output polarity control fields
`define OPC_BIT_AUX_TWO_INV   5
`define OPC_BIT_MUTE_INV      4
`define OPC_BIT_AUX_ZERO_INV  3

// volume status fields
`define OPC_BIT_LEFT_RAMP     5
`define OPC_BIT_LEFT_DONE     4
`define OPC_BIT_RIGHT_RAMP    1
`define OPC_BIT_RIGHT_DONE    0
`define OPC_MASK_VOL_RW       8'hCC

// detected rate and ratio fields
`define OPC_RATE_MSB          6
`define OPC_RATE_LSB          4
`define OPC_RATIO_MSB         3
`define OPC_RATIO_LSB         0
`define OPC_MASK_RATE_RW      8'h80

// unused ratio codes
`define OPC_RATIO_RSVD_A      4'h5
`define OPC_RATIO_RSVD_B      4'hC
`define OPC_RATIO_RSVD_C      4'hF

// least ratio code usable without the pll (64 times the sample rate)
`define OPC_MIN_RATIO_NO_PLL  4'h3

`endif

/* opc_pkg.sv */
// types for the output polarity and clock status register group
package opc_pkg;

  // detected sample rate codes
  typedef enum logic [2:0] {
    OPC_FS_ERROR  = 3'h0,
    OPC_FS_8K     = 3'h1,
    OPC_FS_16K    = 3'h2,
    OPC_FS_48K    = 3'h3,
    OPC_FS_96K    = 3'h4,
    OPC_FS_192K   = 3'h5,
    OPC_FS_384K   = 3'h6,
    OPC_FS_UNUSED = 3'h7
  } opc_rate_t;

  // detected master clock ratio codes
  typedef enum logic [3:0] {
    OPC_RATIO_ERROR = 4'h0,
    OPC_RATIO_32    = 4'h1,
    OPC_RATIO_48    = 4'h2,
    OPC_RATIO_64    = 4'h3,
    OPC_RATIO_128   = 4'h4,
    OPC_RATIO_RES5  = 4'h5,
    OPC_RATIO_192   = 4'h6,
    OPC_RATIO_384   = 4'h7,
    OPC_RATIO_512   = 4'h8,
    OPC_RATIO_768   = 4'h9,
    OPC_RATIO_1024  = 4'hA,
    OPC_RATIO_1536  = 4'hB,
    OPC_RATIO_RESC  = 4'hC,
    OPC_RATIO_2048  = 4'hD,
    OPC_RATIO_3072  = 4'hE,
    OPC_RATIO_RESF  = 4'hF
  } opc_ratio_t;

endpackage : opc_pkg

/* opc_polarity_stage.sv */
// one output pin stage with selectable polarity
`timescale 1ns/100ps

module opc_polarity_stage (
  // clock and reset
  input  wire logic mclk_i,
  input  wire logic sys_rst_i,
  // selected source and polarity
  input  wire logic src_i,
  input  wire logic invert_i,
  // pin level
  output logic      pin_o
);

  logic next_pin;

  // invert the selected source when asked
  always_comb begin
    next_pin = src_i ^ invert_i;
  end

  // register the pin level
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      pin_o <= 1'b0;
    end else begin
      pin_o <= next_pin;
    end
  end

endmodule : opc_polarity_stage

/* opc_host.sv */
// host model driving the register port of the status block
`timescale 1ns/100ps
module opc_host (
  // clock
  input  wire logic       mclk_i,
  // register port towards the block
  output logic      [7:0] reg_addr_o,
  output logic      [7:0] reg_wdata_o,
  output logic            reg_wr_o,
  output logic            reg_rd_o,
  input  wire logic [7:0] reg_rdata_i,
  input  wire logic       reg_rvalid_i
);
  // idle port at time zero
  initial begin
    {reg_addr_o, reg_wdata_o, reg_wr_o, reg_rd_o} = '0;
  end
  // one byte write; address and data go stale-inverted once released
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk_i);
    {reg_addr_o, reg_wdata_o, reg_wr_o} = {a, d, 1'b1};
    @(negedge mclk_i);
    {reg_addr_o, reg_wdata_o, reg_wr_o} = {~a, ~d, 1'b0};
  endtask : wr
  // one byte read, bounded wait for the answer
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
    int i;
    @(negedge mclk_i);
    {reg_addr_o, reg_rd_o} = {a, 1'b1};
    @(negedge mclk_i);
    {reg_addr_o, reg_rd_o} = {~a, 1'b0};
    for (i = 0; i < 3 && reg_rvalid_i !== 1'b1; i++) @(negedge mclk_i);
    ok = (reg_rvalid_i === 1'b1);
    d = reg_rdata_i;
  endtask : rd
endmodule : opc_host

/* opc_output_polarity_and_clock_status_props.sv */
// assertions on the ports of the polarity and status block
`timescale 1ns/100ps
module opc_props #(
  parameter logic [7:0] DIE_ID = 8'h5A
) (
  // clock and reset
  input wire logic       mclk_i,
  input wire logic       sys_rst_i,
  // register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic       reg_wr_i,
  input wire logic       reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic       reg_rvalid_o,
  // pins
  input wire logic       aux_two_src_i,
  input wire logic       mute_src_i,
  input wire logic       aux_zero_src_i,
  input wire logic       aux_io_two_dir_out_i,
  input wire logic       aux_io_two_o,
  input wire logic       aux_io_two_oe_n_o,
  input wire logic       mute_o,
  input wire logic       aux_io_zero_o,
  // status
  input wire logic       left_volume_ramping_i,
  input wire logic       left_volume_done_i,
  input wire logic       right_volume_ramping_i,
  input wire logic       right_volume_done_i,
  input wire logic [2:0] detected_sample_rate_i,
  input wire logic [3:0] detected_master_clock_ratio_i,
  input wire logic       pll_enable_i,
  input wire logic       mclk_over_limit_i,
  input wire logic       clock_error_o
);
  logic [7:0] pol_q;
  logic [7:0] next_pol_q;
  logic       cfg_err;
  // shadow of the polarity register
  always_comb begin
    next_pol_q = (reg_wr_i && reg_addr_i == 8'h57) ? reg_wdata_i : pol_q;
  end
  always_ff @(posedge mclk_i) begin
    pol_q <= sys_rst_i ? 8'h00 : next_pol_q;
  end
  // clocking combinations counted as errors
  assign cfg_err = detected_sample_rate_i inside {3'h0, 3'h7} || mclk_over_limit_i
    || detected_master_clock_ratio_i inside {4'h0, 4'h5, 4'hC, 4'hF}
    || (!pll_enable_i && detected_master_clock_ratio_i < 4'h3);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  chk_aux_two_pol: assert property (
    !$past(sys_rst_i) && !$past(sys_rst_i, 2) |-> aux_io_two_o == ($past(aux_two_src_i, 2) ^ $past(pol_q[5], 2)))
    else $error("aux two level wrong");
  chk_mute_pol: assert property (
    !$past(sys_rst_i) |-> mute_o == ($past(mute_src_i) ^ $past(pol_q[4]))) else $error("mute level wrong");
  chk_aux_zero_pol: assert property (
    !$past(sys_rst_i) |-> aux_io_zero_o == ($past(aux_zero_src_i) ^ $past(pol_q[3]))) else $error("aux zero wrong");
  chk_aux_two_dir: assert property (
    !$past(sys_rst_i) |-> aux_io_two_oe_n_o == !$past(aux_io_two_dir_out_i)) else $error("aux two enable wrong");
  chk_vol_status: assert property (
    reg_rd_i && reg_addr_i == 8'h59 && !$past(sys_rst_i) |=> {reg_rdata_o[5:4], reg_rdata_o[1:0]} ==
    $past({left_volume_ramping_i, left_volume_done_i, right_volume_ramping_i, right_volume_done_i}, 2))
    else $error("volume status wrong");
  chk_rate_ratio: assert property (
    reg_rd_i && reg_addr_i == 8'h5B && !$past(sys_rst_i) |=> reg_rdata_o[6:0] ==
    $past({detected_sample_rate_i, detected_master_clock_ratio_i}, 2)) else $error("rate or ratio wrong");
  chk_clock_err: assert property (
    !$past(sys_rst_i) |-> clock_error_o == $past(cfg_err)) else $error("clock error wrong");
  chk_die_ident: assert property (
    reg_rd_i && reg_addr_i == 8'h58 |=> reg_rvalid_o && reg_rdata_o == DIE_ID) else $error("ident wrong");
  chk_pol_read: assert property (
    reg_rd_i && reg_addr_i == 8'h57 |=> reg_rdata_o == $past(pol_q)) else $error("polarity read wrong");
  cov_pol_write: cover property (reg_wr_i && reg_addr_i == 8'h57);
  cov_vol_read: cover property (reg_rd_i && reg_addr_i == 8'h59);
  cov_err_rise: cover property ($rose(clock_error_o));
endmodule : opc_props
bind opc_output_polarity_and_clock_status opc_props #(.DIE_ID(DIE_ID)) u_opc_props (.*);

/* opc_output_polarity_and_clock_status_test.sv */
// self-checking bench for the polarity and status block
`timescale 1ns/100ps
module opc_output_polarity_and_clock_status_test;
  localparam logic [7:0] DIE_ID = 8'h3C; // arbitrary identification value
  logic       mclk_i = 1'b0;
  logic       sys_rst_i = 1'b1;
  logic [7:0] addr, wdata, rdata, got;
  logic       wr, rd, rvalid, ok, s2, sm, s0, dir, lr, ld, rr, rdn, pll, over, cerr, p2, p2oe_n, pm, p0;
  logic [2:0] rate;
  logic [3:0] ratio;
  int         n_mismatch = 0;
  int         cmp_count = 0;
  localparam logic [18:0] ERR_MAP = 19'h5_91A1; // expected clock error, one bit per rate step
  opc_output_polarity_and_clock_status #(.DIE_ID(DIE_ID)) u_opc_output_polarity_and_clock_status (
    .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .aux_two_src_i(s2), .mute_src_i(sm),
    .aux_zero_src_i(s0), .aux_io_two_dir_out_i(dir), .aux_io_two_o(p2), .aux_io_two_oe_n_o(p2oe_n),
    .mute_o(pm), .aux_io_zero_o(p0), .left_volume_ramping_i(lr), .left_volume_done_i(ld),
    .right_volume_ramping_i(rr), .right_volume_done_i(rdn), .detected_sample_rate_i(rate),
    .detected_master_clock_ratio_i(ratio), .pll_enable_i(pll), .mclk_over_limit_i(over), .clock_error_o(cerr));
  opc_host u_opc_host (.mclk_i(mclk_i), .reg_addr_o(addr), .reg_wdata_o(wdata), .reg_wr_o(wr),
    .reg_rd_o(rd), .reg_rdata_i(rdata), .reg_rvalid_i(rvalid));
  // compare and count
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // read a register and compare, answer must arrive
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    u_opc_host.rd(a, got, ok);
    check("rvalid", {7'h00, ok}, 8'h01);
    check("rdata", got, exp);
  endtask : rd_chk
  // polarity bits follow writes, pins follow polarity
  task automatic t_polarity;
    {dir, s2, sm, s0} = 4'b1101;
    rd_chk(8'h57, 8'h00);
    u_opc_host.wr(8'h57, 8'h38);
    repeat (3) @(negedge mclk_i);
    check("pins", {4'h0, p2oe_n, p2, pm, p0}, 8'h02);
    rd_chk(8'h57, 8'h38);
    u_opc_host.wr(8'h57, 8'hC7);
    repeat (3) @(negedge mclk_i);
    check("pins", {4'h0, p2oe_n, p2, pm, p0}, 8'h05);
    rd_chk(8'h57, 8'hC7);
    dir = 1'b0;
    repeat (2) @(negedge mclk_i);
    check("pin enable", {7'h00, p2oe_n}, 8'h01);
  endtask : t_polarity
  // identity ignores writes, an unmapped offset reads zero, and volume status live bits override writes
  task automatic t_status;
    u_opc_host.wr(8'h58, ~DIE_ID);
    rd_chk(8'h58, DIE_ID);
    rd_chk(8'h5A, 8'h00);
    for (int k = 0; k < 2; k++) begin
      {lr, ld, rr, rdn} = k ? 4'h6 : 4'h9;
      u_opc_host.wr(8'h59, 8'hFF);
      rd_chk(8'h59, {2'b11, lr, ld, 2'b11, rr, rdn});
    end
  endtask : t_status
  // every rate and ratio code, with the clock error beside it
  task automatic t_rate;
    u_opc_host.wr(8'h5B, 8'hFF);
    for (int i = 0; i < 19; i++) begin
      {pll, over} = {i < 16 || i > 17, i == 18};
      {rate, ratio} = (i < 16) ? {3'(i % 8), 4'(i)} : {3'h3, 4'(i - 14)};
      rd_chk(8'h5B, {1'b1, rate, ratio});
      check("clock error", {7'h00, cerr}, {7'h00, ERR_MAP[i]});
    end
  endtask : t_rate
  // report and stop
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : give_verdict
  // clock source
  initial begin
    forever #5 mclk_i = ~mclk_i;
  end
  // reset, scenarios and verdict
  initial begin
    {s2, sm, s0, dir, lr, ld, rr, rdn, over, rate, ratio} = '0;
    pll = 1'b1;
    repeat (16) @(negedge mclk_i);
    sys_rst_i = 1'b0;
    t_polarity();
    t_status();
    t_rate();
    give_verdict();
  end
endmodule : opc_output_polarity_and_clock_status_test
